// File: verilog/comfsm_mode_seq.sv
// operating-mode sequencer with AXI4-Lite register slave
// assumes: all inputs synchronous to core_clk; events from the program
// engine are one-cycle pulses, key position is a level
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`include "comfsm_cfg.svh"
module comfsm_mode_seq import comfsm_pkg::*; (
	// clock and reset
	input	wire logic		core_clk,
	input	wire logic		sys_rst,
	// axi4-lite slave
	input	wire logic [7:0]	s_axi_awaddr,
	input	wire logic		s_axi_awvalid,
	output	logic			s_axi_awready,
	input	wire logic [31:0]	s_axi_wdata,
	input	wire logic [3:0]	s_axi_wstrb,
	input	wire logic		s_axi_wvalid,
	output	logic			s_axi_wready,
	output	logic [1:0]		s_axi_bresp,
	output	logic			s_axi_bvalid,
	input	wire logic		s_axi_bready,
	input	wire logic [7:0]	s_axi_araddr,
	input	wire logic		s_axi_arvalid,
	output	logic			s_axi_arready,
	output	logic [31:0]		s_axi_rdata,
	output	logic [1:0]		s_axi_rresp,
	output	logic			s_axi_rvalid,
	input	wire logic		s_axi_rready,
	// key switch and straps
	input	wire logic [1:0]	key_position,
	input	wire logic		hot_restart_capable,
	input	wire logic		flash_card_present,
	input	wire logic		modules_present,
	// program engine events
	input	wire logic		startup_error,
	input	wire logic		startup_done,
	input	wire logic		startup_stop_instr,
	input	wire logic		user_stop_instr,
	input	wire logic		runtime_err_no_handler,
	input	wire logic		breakpoint_hit,
	input	wire logic		pd_test_active,
	// mode status and enables
	output	comfsm_mode_type	mode_status,
	output	logic			outputs_substitute,
	output	logic			module_check_en,
	output	logic			user_prog_en,
	output	logic			io_refresh_en,
	output	logic			irq_service_en,
	output	logic			single_step_en,
	output	logic			comm_if_en,
	output	logic			global_data_accept,
	// startup actions
	output	logic			init_system_data,
	output	logic			clear_nonretentive,
	output	logic			clear_all_data,
	output	logic			delete_runtime_db,
	output	logic			restore_db,
	output	logic			load_input_image,
	output	logic			warm_start_handler,
	output	logic			hot_start_handler,
	output	logic			cold_start_handler,
	output	logic			start_at_cyclic_main,
	output	logic			resume_at_break,
	// memory reset actions
	output	logic			memory_reset_switch_position_clear_user,
	output	logic			memory_reset_switch_position_restore_defaults,
	output	logic			memory_reset_switch_position_copy_flash
);

////////////////////////////////////////////////////////////////////////////////
function automatic logic reg_hit(input logic [7:0] a);
	reg_hit = (a == `COMFSM_CTRL_OFS) || (a == `COMFSM_CFG_OFS) || (a == `COMFSM_STAT_OFS);
endfunction

function automatic logic is_run_pos(input logic [1:0] k);
	is_run_pos = (k == KEY_RUN) || (k == KEY_RUN_P);
endfunction

////////////////////////////////////////////////////////////////////////////////
// register slave
logic			aw_held, w_held, wstrb0;
logic [7:0]		awaddr_q;
logic [31:0]		wdata_q;
logic [`COMFSM_CMD_W-1:0]	cmd;
logic [`COMFSM_CFG_W-1:0]	cfg;
logic			next_aw_held, next_w_held, next_wstrb0;
logic [7:0]		next_awaddr_q;
logic [31:0]		next_wdata_q, next_rdata;
logic [`COMFSM_CMD_W-1:0]	next_cmd;
logic [`COMFSM_CFG_W-1:0]	next_cfg;
logic			next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
logic [1:0]		next_bresp, next_rresp;
comfsm_mode_type	mode;
comfsm_restart_type	restart;
comfsm_phase_type	phase;
logic			hold_from_run;

always_comb begin
	next_aw_held = aw_held;
	next_w_held = w_held;
	next_awaddr_q = awaddr_q;
	next_wdata_q = wdata_q;
	next_wstrb0 = wstrb0;
	next_bvalid = s_axi_bvalid;
	next_bresp = s_axi_bresp;
	next_arready = s_axi_arready;
	next_rvalid = s_axi_rvalid;
	next_rdata = s_axi_rdata;
	next_rresp = s_axi_rresp;
	next_cmd = '0;
	next_cfg = cfg;
	if (s_axi_awvalid && s_axi_awready) begin
		next_aw_held = 1'b1;
		next_awaddr_q = s_axi_awaddr;
	end
	if (s_axi_wvalid && s_axi_wready) begin
		next_w_held = 1'b1;
		next_wdata_q = s_axi_wdata;
		next_wstrb0 = s_axi_wstrb[0];
	end
	if (s_axi_bvalid && s_axi_bready)
		next_bvalid = 1'b0;
	if (aw_held && w_held && !s_axi_bvalid) begin
		next_aw_held = 1'b0;
		next_w_held = 1'b0;
		next_bvalid = 1'b1;
		next_bresp = reg_hit(awaddr_q) ? `COMFSM_RESP_OKAY : `COMFSM_RESP_SLVERR;
		// all fields live in byte lane 0; status is read-only
		if (wstrb0 && awaddr_q == `COMFSM_CTRL_OFS)
			next_cmd = wdata_q[`COMFSM_CMD_W-1:0];
		if (wstrb0 && awaddr_q == `COMFSM_CFG_OFS)
			next_cfg = wdata_q[`COMFSM_CFG_W-1:0];
	end
	next_awready = !next_aw_held && !next_bvalid;
	next_wready = !next_w_held && !next_bvalid;
	if (s_axi_arvalid && s_axi_arready) begin
		next_arready = 1'b0;
		next_rvalid = 1'b1;
		next_rresp = reg_hit(s_axi_araddr) ? `COMFSM_RESP_OKAY : `COMFSM_RESP_SLVERR;
		next_rdata = 32'h00000000;
		if (s_axi_araddr == `COMFSM_CFG_OFS)
			next_rdata[`COMFSM_CFG_W-1:0] = cfg;
		if (s_axi_araddr == `COMFSM_STAT_OFS)
			next_rdata[7:0] = {hot_restart_capable, hold_from_run, phase, restart, mode};
	end
	if (s_axi_rvalid && s_axi_rready) begin
		next_rvalid = 1'b0;
		next_arready = 1'b1;
	end
end

always_ff @(posedge core_clk) begin
	if (sys_rst) begin
		aw_held <= 1'b0;
		w_held <= 1'b0;
		awaddr_q <= 8'h00;
		wdata_q <= 32'h00000000;
		wstrb0 <= 1'b0;
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `COMFSM_RESP_OKAY;
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `COMFSM_RESP_OKAY;
		cmd <= '0;
		cfg <= `COMFSM_CFG_RST;
	end else begin
		aw_held <= next_aw_held;
		w_held <= next_w_held;
		awaddr_q <= next_awaddr_q;
		wdata_q <= next_wdata_q;
		wstrb0 <= next_wstrb0;
		s_axi_awready <= next_awready;
		s_axi_wready <= next_wready;
		s_axi_bvalid <= next_bvalid;
		s_axi_bresp <= next_bresp;
		s_axi_arready <= next_arready;
		s_axi_rvalid <= next_rvalid;
		s_axi_rdata <= next_rdata;
		s_axi_rresp <= next_rresp;
		cmd <= next_cmd;
		cfg <= next_cfg;
	end
end

////////////////////////////////////////////////////////////////////////////////
// mode machine
logic		key_run, key_run_q, key_memory_reset_switch_position_q, auto_armed;
logic		key_stop, cmd_stop, stop_req, hold_req, startup_req, run_req, start_trig, memory_reset_switch_position_req;
comfsm_mode_type	next_mode;
comfsm_restart_type	next_restart;
comfsm_phase_type	next_phase;
logic		next_hold_from_run;
logic [10:0]	next_act;
logic [2:0]	next_memory_reset_switch_position;

assign key_run = is_run_pos(key_position);
assign key_stop = !key_run;
assign cmd_stop = cmd[`COMFSM_CMD_PD_STOP] || cmd[`COMFSM_CMD_COMM_STOP];

always_comb begin
	// auto start is judged only in the first cycle after power-on
	start_trig = (key_run && !key_run_q) || cmd[`COMFSM_CMD_PD_START] || cmd[`COMFSM_CMD_COMM_START]
		|| cmd[`COMFSM_CMD_COMM_RESUME] || (auto_armed && cfg[`COMFSM_CFG_AUTO_BIT]);
	stop_req = 1'b0;
	hold_req = 1'b0;
	startup_req = 1'b0;
	run_req = 1'b0;
	case (mode)
		MODE_STOP: begin
			// a stop command in the same cycle as a start keeps the block in stop
			stop_req = cmd_stop;
			startup_req = start_trig && key_run && modules_present;
		end
		MODE_STARTUP: begin
			stop_req = startup_error || key_stop || cmd_stop || startup_stop_instr;
			hold_req = breakpoint_hit && pd_test_active;
			run_req = startup_done && phase == PH_HANDLER;
		end
		MODE_RUN: begin
			stop_req = runtime_err_no_handler || key_stop || cmd_stop || user_stop_instr;
			hold_req = breakpoint_hit && pd_test_active;
		end
		MODE_HOLD: begin
			stop_req = key_stop || cmd_stop;
			startup_req = cmd[`COMFSM_CMD_EXIT_HOLD] && !hold_from_run;
			run_req = cmd[`COMFSM_CMD_EXIT_HOLD] && hold_from_run;
		end
		default: stop_req = 1'b1;
	endcase
	memory_reset_switch_position_req = (mode == MODE_STOP)
		&& ((key_position == KEY_MEMORY_RESET_SWITCH_POSITION && !key_memory_reset_switch_position_q) || cmd[`COMFSM_CMD_PD_MEMORY_RESET_SWITCH_POSITION]);
end

always_comb begin
	next_mode = mode;
	next_phase = phase;
	next_restart = restart;
	next_hold_from_run = hold_from_run;
	// {init_sys, clr_nonret, clr_all, del_db, restore_db, load_img, warm_h, hot_h, cold_h, main, resume}
	next_act = 11'h000;
	next_memory_reset_switch_position = 3'h0;
	if (stop_req) begin
		next_mode = MODE_STOP;
	end else if (hold_req) begin
		next_mode = MODE_HOLD;
		next_hold_from_run = (mode == MODE_RUN);
	end else if (startup_req) begin
		next_mode = MODE_STARTUP;
		if (mode == MODE_STOP) begin
			next_phase = PH_INIT;
			// hot falls back to warm on the small variant
			next_restart = (cfg[1:0] == RST_HOT && !hot_restart_capable) ? RST_WARM
				: comfsm_restart_type'(cfg[1:0]);
		end
	end else if (run_req) begin
		next_mode = MODE_RUN;
		if (mode == MODE_STARTUP) begin
			next_act[1] = (restart != RST_HOT);
			next_act[0] = (restart == RST_HOT);
		end
	end
	if (mode == MODE_STARTUP && next_mode == MODE_STARTUP) begin
		case (phase)
			PH_INIT: begin
				next_phase = PH_IMAGE;
				next_act[10] = (restart == RST_WARM);
				next_act[9] = (restart == RST_WARM);
				next_act[8:6] = {3{restart == RST_COLD}};
			end
			PH_IMAGE: begin
				next_phase = PH_HANDLER;
				next_act[5] = (restart != RST_HOT);
			end
			PH_HANDLER: next_phase = PH_HANDLER;
			default: next_phase = PH_INIT;
		endcase
	end
	if (next_mode == MODE_STARTUP && next_phase == PH_HANDLER) begin
		next_act[4] = (next_restart == RST_WARM);
		next_act[3] = (next_restart == RST_HOT);
		next_act[2] = (next_restart == RST_COLD);
	end
	// comm parameters, diagnostics, time and meters are outside this reset
	if (memory_reset_switch_position_req && next_mode == MODE_STOP)
		next_memory_reset_switch_position = {1'b1, 1'b1, flash_card_present};
end

always_ff @(posedge core_clk) begin
	if (sys_rst) begin
		mode <= MODE_STOP;
		phase <= PH_INIT;
		restart <= RST_WARM;
		hold_from_run <= 1'b0;
		key_run_q <= 1'b0;
		key_memory_reset_switch_position_q <= 1'b0;
		auto_armed <= 1'b1;
		mode_status <= MODE_STOP;
		{outputs_substitute, module_check_en} <= 2'h3;
		{user_prog_en, io_refresh_en, irq_service_en, single_step_en} <= 4'h0;
		{comm_if_en, global_data_accept} <= 2'h3;
		{init_system_data, clear_nonretentive, clear_all_data, delete_runtime_db, restore_db,
			load_input_image, warm_start_handler, hot_start_handler, cold_start_handler,
			start_at_cyclic_main, resume_at_break} <= 11'h000;
		{memory_reset_switch_position_clear_user, memory_reset_switch_position_restore_defaults, memory_reset_switch_position_copy_flash} <= 3'h0;
	end else begin
		mode <= next_mode;
		phase <= next_phase;
		restart <= next_restart;
		hold_from_run <= next_hold_from_run;
		key_run_q <= key_run;
		key_memory_reset_switch_position_q <= (key_position == KEY_MEMORY_RESET_SWITCH_POSITION);
		auto_armed <= 1'b0;
		mode_status <= next_mode;
		outputs_substitute <= (next_mode == MODE_STOP);
		module_check_en <= (next_mode == MODE_STOP);
		user_prog_en <= (next_mode == MODE_RUN) || (next_mode == MODE_STARTUP);
		io_refresh_en <= (next_mode == MODE_RUN);
		irq_service_en <= (next_mode == MODE_RUN);
		single_step_en <= (next_mode == MODE_HOLD);
		comm_if_en <= 1'b1;
		global_data_accept <= 1'b1;
		{init_system_data, clear_nonretentive, clear_all_data, delete_runtime_db, restore_db,
			load_input_image, warm_start_handler, hot_start_handler, cold_start_handler,
			start_at_cyclic_main, resume_at_break} <= next_act;
		{memory_reset_switch_position_clear_user, memory_reset_switch_position_restore_defaults, memory_reset_switch_position_copy_flash} <= next_memory_reset_switch_position;
	end
end

////////////////////////////////////////////////////////////////////////////////
// checks
property p_power_stop;
	@(posedge core_clk) $fell(sys_rst) |-> mode_status == MODE_STOP && outputs_substitute;
endproperty
a_power_stop: assert property (p_power_stop) else $error("not in stop after reset");

property p_stop_safe;
	@(posedge core_clk) disable iff (sys_rst)
	mode_status == MODE_STOP |-> outputs_substitute && !user_prog_en && !io_refresh_en;
endproperty
a_stop_safe: assert property (p_stop_safe) else $error("stop without safe outputs");

property p_comm_on;
	@(posedge core_clk) disable iff (sys_rst) comm_if_en && global_data_accept;
endproperty
a_comm_on: assert property (p_comm_on) else $error("communication disabled");

property p_stop_prio;
	@(posedge core_clk) disable iff (sys_rst)
	mode != MODE_STOP && cmd[`COMFSM_CMD_PD_STOP] |=> mode_status == MODE_STOP;
endproperty
a_stop_prio: assert property (p_stop_prio) else $error("stop request lost");

property p_hold_gate;
	@(posedge core_clk) disable iff (sys_rst)
	$rose(mode_status == MODE_HOLD) |-> $past(pd_test_active) && single_step_en;
endproperty
a_hold_gate: assert property (p_hold_gate) else $error("hold without test");

property p_hold_back;
	@(posedge core_clk) disable iff (sys_rst)
	mode == MODE_HOLD && hold_from_run && cmd[`COMFSM_CMD_EXIT_HOLD] && key_run && !cmd_stop
	|=> mode_status == MODE_RUN;
endproperty
a_hold_back: assert property (p_hold_back) else $error("exit hold missed");

property p_start_key;
	@(posedge core_clk) disable iff (sys_rst)
	mode == MODE_STOP ##1 mode == MODE_STARTUP |-> $past(key_run);
endproperty
a_start_key: assert property (p_start_key) else $error("start without run key");

property p_run_main;
	@(posedge core_clk) disable iff (sys_rst)
	mode == MODE_STARTUP ##1 mode == MODE_RUN |-> start_at_cyclic_main != resume_at_break;
endproperty
a_run_main: assert property (p_run_main) else $error("run entry without start point");

property p_memory_reset_switch_position_stop;
	@(posedge core_clk) disable iff (sys_rst)
	memory_reset_switch_position_clear_user |-> $past(mode) == MODE_STOP && mode == MODE_STOP && memory_reset_switch_position_restore_defaults;
endproperty
a_memory_reset_switch_position_stop: assert property (p_memory_reset_switch_position_stop) else $error("memory reset outside stop");

property p_cold_clear;
	@(posedge core_clk) disable iff (sys_rst)
	clear_all_data |-> restart == RST_COLD && delete_runtime_db && restore_db ##1 load_input_image;
endproperty
a_cold_clear: assert property (p_cold_clear) else $error("cold restart sequence wrong");

endmodule

// File: verilog/comfsm_cfg.svh
// offsets, field positions, reset values of the operating-mode sequencer
// assumes: included by the design and the bench; 32-bit AXI4-Lite word map
// Operation
// - exactly four modes: stop, startup, run, hold; always in one of them
// - stop checks module presence, holds I/O at initial state, no user program
// - warm restart starts at program begin, clears only non-retentive data
// - warm and cold restart load input image, then start at cyclic main block
// - cold restart deletes runtime blocks, restores blocks, clears all data
// - hot restart resumes at break point, clears nothing, large variant only
// - run executes program, refreshes I/O, serves interrupts and errors
// - hold suspends program, allows single step, only under device test
// - multipoint communication interface works in every mode
// - power-on enters stop
// - stop to startup on key, command, auto start, comm; key in run (auto start never fires here: cfg resets with the auto bit clear)
// - startup to stop on error, key or command stop, stop instruction, comm
// - startup breakpoint enters hold; exit-hold returns to startup
// - hold to stop on key or command stop, or comm stop
// - successful startup enters run
// - run to stop on unhandled error, key or command stop, instruction, comm
// - run breakpoint enters hold; exit-hold returns to run
// - simultaneous requests: stop beats hold beats startup beats run
// - stop drives all outputs to substitute values
// - stop still accepts global data and passive one-way communication
// - memory reset only in stop, from key position or device command
// - memory reset clears program, restores defaults, copies flash, keeps comm
// - startup runs warm, hot or cold handler by restart type
`ifndef COMFSM_CFG_SVH
`define COMFSM_CFG_SVH
`define COMFSM_CTRL_OFS 8'h00
`define COMFSM_CFG_OFS 8'h04
`define COMFSM_STAT_OFS 8'h08
`define COMFSM_CMD_PD_START 0
`define COMFSM_CMD_PD_STOP 1
`define COMFSM_CMD_COMM_START 2
`define COMFSM_CMD_COMM_RESUME 3
`define COMFSM_CMD_COMM_STOP 4
`define COMFSM_CMD_EXIT_HOLD 5
`define COMFSM_CMD_PD_MEMORY_RESET_SWITCH_POSITION 6
`define COMFSM_CMD_W 7
`define COMFSM_CFG_AUTO_BIT 2
`define COMFSM_CFG_W 3
`define COMFSM_CFG_RST 3'h0
`define COMFSM_RESP_OKAY 2'h0
`define COMFSM_RESP_SLVERR 2'h2
`endif

// File: verilog/comfsm_pkg.sv
// types of the operating-mode sequencer
// assumes: nothing beyond the constants header
package comfsm_pkg;
	typedef enum logic [1:0] {
		MODE_STOP	= 2'b00,
		MODE_STARTUP	= 2'b01,
		MODE_RUN	= 2'b10,
		MODE_HOLD	= 2'b11
	} comfsm_mode_type;
	typedef enum logic [1:0] {
		RST_WARM	= 2'b00,
		RST_COLD	= 2'b01,
		RST_HOT	= 2'b10
	} comfsm_restart_type;
	typedef enum logic [1:0] {
		PH_INIT	= 2'b00,
		PH_IMAGE	= 2'b01,
		PH_HANDLER	= 2'b10
	} comfsm_phase_type;
	typedef enum logic [1:0] {
		KEY_STOP	= 2'b00,
		KEY_RUN	= 2'b01,
		KEY_RUN_P	= 2'b10,
		KEY_MEMORY_RESET_SWITCH_POSITION	= 2'b11
	} comfsm_key_type;
endpackage

// File: bench/comfsm_engine_model.sv
// program engine stand-in: reports startup completion to the sequencer
// assumes: handler levels come from the sequencer on the same clock
module comfsm_engine_model (
	// clock and reset
	input	wire logic	core_clk,
	input	wire logic	sys_rst,
	// handler level and pace
	input	wire logic	handler_on,
	input	wire logic	slow,
	// completion
	output	logic		startup_done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0]	cnt;
	logic [5:0]	next_cnt;
	logic		next_done;
	////////////////////////////////////////////////////////////
	// saturating count: a handler level held past 63 cycles still reads as done; the count clears when the level drops
	always_comb begin
		next_cnt = handler_on ? cnt + {5'h00, ~&cnt} : 6'h00;
		next_done = handler_on && (cnt >= (slow ? 6'h28 : 6'h02));
	end
	always_ff @(posedge core_clk) begin
		cnt <= sys_rst ? 6'h00 : next_cnt;
		startup_done <= sys_rst ? 1'b0 : next_done;
	end
endmodule

// File: bench/test_comfsm_mode_seq.sv
// bench of the operating-mode sequencer: register bus, key, engine events
// assumes: design, package and engine stand-in are compiled first
`include "comfsm_cfg.svh"
module test_comfsm_mode_seq import comfsm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic			core_clk, sys_rst, slow, seen_clr, startup_done;
	logic [7:0]		s_axi_awaddr, s_axi_araddr, en_vec;
	logic [31:0]		s_axi_wdata, s_axi_rdata;
	logic [3:0]		s_axi_wstrb;
	logic [1:0]		s_axi_bresp, s_axi_rresp, key_position;
	logic			s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic			s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic			hot_restart_capable, flash_card_present, modules_present, pd_test_active;
	logic [4:0]		eng;
	logic [13:0]		act, seen;
	comfsm_mode_type	mode_status;
	int			err_total, checks;
	localparam logic [7:0] EN_TAB [4] = '{8'hC3, 8'h23, 8'h3B, 8'h07};
	////////////////////////////////////////////////////////////
	comfsm_mode_seq dut (
		.core_clk(core_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.key_position(key_position), .hot_restart_capable(hot_restart_capable),
		.flash_card_present(flash_card_present), .modules_present(modules_present),
		.startup_error(eng[0]), .startup_done(startup_done), .startup_stop_instr(eng[1]),
		.user_stop_instr(eng[2]), .runtime_err_no_handler(eng[3]), .breakpoint_hit(eng[4]),
		.pd_test_active(pd_test_active), .mode_status(mode_status),
		.outputs_substitute(en_vec[7]), .module_check_en(en_vec[6]), .user_prog_en(en_vec[5]),
		.io_refresh_en(en_vec[4]), .irq_service_en(en_vec[3]), .single_step_en(en_vec[2]),
		.comm_if_en(en_vec[1]), .global_data_accept(en_vec[0]),
		.init_system_data(act[13]), .clear_nonretentive(act[12]), .clear_all_data(act[11]),
		.delete_runtime_db(act[10]), .restore_db(act[9]), .load_input_image(act[8]),
		.start_at_cyclic_main(act[7]), .resume_at_break(act[6]), .warm_start_handler(act[5]),
		.hot_start_handler(act[4]), .cold_start_handler(act[3]), .memory_reset_switch_position_clear_user(act[2]),
		.memory_reset_switch_position_restore_defaults(act[1]), .memory_reset_switch_position_copy_flash(act[0])
	);
	comfsm_engine_model engine (
		.core_clk(core_clk), .sys_rst(sys_rst), .handler_on(act[5] | act[4] | act[3]), .slow(slow),
		.startup_done(startup_done)
	);
	////////////////////////////////////////////////////////////
	// pulses are one cycle wide, so they are gathered here
	always @(posedge core_clk)
		seen <= seen_clr ? 14'h0000 : seen | act;
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, checks);
		if (err_total == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		err_total++;
		$display("[ERR] %0t got %h exp %h", $time, 32'h0, 32'h1);
		close_out();
	endtask
	task automatic wait_mode(input comfsm_mode_type m);
		for (int n = 0; n < 90; n++) begin
			@(posedge core_clk);
			if (mode_status === m) begin
				chk({mode_status, en_vec}, {m, EN_TAB[m]});
				return;
			end
		end
		tmo();
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				done = 1'b1;
				s_axi_bready <= 1'b0;
				chk(s_axi_bresp, er);
			end
		end
		if (!done)
			tmo();
		@(posedge core_clk);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !done; n++) begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				done = 1'b1;
				s_axi_rready <= 1'b0;
				chk(s_axi_rdata & mask, ed);
				chk(s_axi_rresp, er);
			end
		end
		if (!done)
			tmo();
		@(posedge core_clk);
	endtask
	task automatic cmd(input int b);
		axi_wr(`COMFSM_CTRL_OFS, 32'h00000001 << b, `COMFSM_RESP_OKAY);
	endtask
	task automatic ev(input logic [4:0] m);
		eng <= m;
		@(posedge core_clk);
		eng <= 5'h00;
		@(posedge core_clk);
	endtask
	task automatic clr();
		seen_clr <= 1'b1;
		@(posedge core_clk);
		seen_clr <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		wait_mode(MODE_STOP);
		axi_rd(`COMFSM_CFG_OFS, 32'h00000007, 32'h00000000, `COMFSM_RESP_OKAY);
		axi_rd(`COMFSM_CTRL_OFS, 32'hFFFFFFFF, 32'h00000000, `COMFSM_RESP_OKAY);
		axi_rd(`COMFSM_STAT_OFS, 32'h00000083, 32'h00000080, `COMFSM_RESP_OKAY);
		axi_rd(8'h0C, 32'hFFFFFFFF, 32'h00000000, `COMFSM_RESP_SLVERR);
		axi_wr(8'h0C, 32'h00000001, `COMFSM_RESP_SLVERR);
		s_axi_wstrb <= 4'h0;
		axi_wr(`COMFSM_CFG_OFS, 32'h00000007, `COMFSM_RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(`COMFSM_CFG_OFS, 32'h00000007, 32'h00000000, `COMFSM_RESP_OKAY);
	endtask
	task automatic t_key();
		cmd(`COMFSM_CMD_PD_START);
		repeat (4) @(posedge core_clk);
		chk(mode_status, MODE_STOP);
		key_position <= KEY_RUN;
		wait_mode(MODE_STARTUP);
		wait_mode(MODE_RUN);
		key_position <= KEY_STOP;
		wait_mode(MODE_STOP);
		modules_present <= 1'b0;
		key_position <= KEY_RUN_P;
		repeat (4) @(posedge core_clk);
		chk(mode_status, MODE_STOP);
		modules_present <= 1'b1;
	endtask
	task automatic t_start(input logic [1:0] rt, input logic cap, input logic [13:0] exp, input int src);
		hot_restart_capable <= cap;
		axi_wr(`COMFSM_CFG_OFS, {30'h0, rt}, `COMFSM_RESP_OKAY);
		axi_rd(`COMFSM_CFG_OFS, 32'h00000007, {30'h0, rt}, `COMFSM_RESP_OKAY);
		clr();
		cmd(src);
		wait_mode(MODE_RUN);
		// the run entry pulse reaches the gatherer one edge later
		@(posedge core_clk);
		chk(seen, exp);
		axi_rd(`COMFSM_STAT_OFS, 32'h00000083, {24'h0, cap, 7'h02}, `COMFSM_RESP_OKAY);
		cmd(`COMFSM_CMD_PD_STOP);
		wait_mode(MODE_STOP);
	endtask
	task automatic t_stops();
		for (int i = 0; i < 4; i++) begin
			cmd(`COMFSM_CMD_PD_START);
			wait_mode(MODE_RUN);
			case (i)
				0: ev(5'h04);
				1: ev(5'h08);
				2: cmd(`COMFSM_CMD_PD_STOP);
				default: cmd(`COMFSM_CMD_COMM_STOP);
			endcase
			wait_mode(MODE_STOP);
		end
		slow <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			cmd(`COMFSM_CMD_PD_START);
			wait_mode(MODE_STARTUP);
			case (i)
				0: ev(5'h01);
				1: ev(5'h02);
				default: cmd(`COMFSM_CMD_COMM_STOP);
			endcase
			wait_mode(MODE_STOP);
		end
	endtask
	task automatic t_hold();
		slow <= 1'b0;
		cmd(`COMFSM_CMD_PD_START);
		wait_mode(MODE_RUN);
		ev(5'h10);
		chk(mode_status, MODE_RUN);
		pd_test_active <= 1'b1;
		ev(5'h10);
		wait_mode(MODE_HOLD);
		axi_rd(`COMFSM_STAT_OFS, 32'h00000043, 32'h00000043, `COMFSM_RESP_OKAY);
		cmd(`COMFSM_CMD_EXIT_HOLD);
		wait_mode(MODE_RUN);
		ev(5'h10);
		wait_mode(MODE_HOLD);
		cmd(`COMFSM_CMD_COMM_STOP);
		wait_mode(MODE_STOP);
		slow <= 1'b1;
		cmd(`COMFSM_CMD_PD_START);
		wait_mode(MODE_STARTUP);
		ev(5'h10);
		wait_mode(MODE_HOLD);
		cmd(`COMFSM_CMD_EXIT_HOLD);
		wait_mode(MODE_STARTUP);
		wait_mode(MODE_RUN);
		ev(5'h10);
		wait_mode(MODE_HOLD);
		key_position <= KEY_STOP;
		wait_mode(MODE_STOP);
		key_position <= KEY_RUN_P;
		wait_mode(MODE_RUN);
		ev(5'h14);
		chk(mode_status, MODE_STOP);
	endtask
	task automatic t_memory_reset_switch_position();
		for (int i = 0; i < 2; i++) begin
			flash_card_present <= i[0];
			clr();
			cmd(`COMFSM_CMD_PD_MEMORY_RESET_SWITCH_POSITION);
			repeat (3) @(posedge core_clk);
			chk(seen, {11'h000, 2'b11, i[0]});
		end
		axi_wr(`COMFSM_CTRL_OFS, 32'h00000003, `COMFSM_RESP_OKAY);
		repeat (3) @(posedge core_clk);
		chk(mode_status, MODE_STOP);
		key_position <= KEY_STOP;
		clr();
		key_position <= KEY_MEMORY_RESET_SWITCH_POSITION;
		repeat (3) @(posedge core_clk);
		chk(seen, 14'h0007);
		key_position <= KEY_RUN_P;
		wait_mode(MODE_RUN);
		clr();
		cmd(`COMFSM_CMD_PD_MEMORY_RESET_SWITCH_POSITION);
		repeat (3) @(posedge core_clk);
		chk({mode_status, seen}, {MODE_RUN, 14'h0000});
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, slow, seen_clr, modules_present, hot_restart_capable} = 5'b10011;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'b00000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h00000000, 4'hF};
		{key_position, flash_card_present, pd_test_active, eng} = {KEY_STOP, 7'h00};
		err_total = 0;
		checks = 0;
		repeat (6) @(posedge core_clk);
		sys_rst <= 1'b0;
		@(posedge core_clk);
		t_reset();
		t_key();
		t_start(2'h0, 1'b1, 14'h31A0, `COMFSM_CMD_PD_START);
		t_start(2'h1, 1'b1, 14'h0F88, `COMFSM_CMD_COMM_START);
		t_start(2'h2, 1'b1, 14'h0050, `COMFSM_CMD_COMM_RESUME);
		t_start(2'h2, 1'b0, 14'h31A0, `COMFSM_CMD_PD_START);
		t_stops();
		t_hold();
		t_memory_reset_switch_position();
		close_out();
	end
endmodule
